// ===== pkg/sys_config_pkg.sv
// Purpose: Constants for the system configuration register bank
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   Configuration words arrive as plain inputs from non-volatile storage
package sys_config_pkg;
    // Register byte offsets
    localparam logic [15:0] OFFSET_CONFIG_CONTROL    = 16'h3B00;
    localparam logic [15:0] OFFSET_DEVICE_IDENTITY   = 16'h3B20;
    localparam logic [15:0] OFFSET_UNLOCK_KEY        = 16'h3B30;
    localparam logic [15:0] OFFSET_OSC_SELECT_CONFIG = 16'h3B40;
    localparam logic [15:0] OFFSET_CODE_PROTECT_CFG  = 16'h3B50;
    // Field positions
    localparam int RAM_EXEC_LSB       = 16;
    localparam int RAM_EXEC_MSB       = 23;
    localparam int TEST_PORT_BIT      = 3;
    localparam int DEBUG_TEST_BIT     = 2;
    localparam int CODE_PROTECT_BIT   = 31;
    // Readable and writable masks of config_control
    localparam logic [31:0] CONTROL_READ_MASK  = 32'h0BFF_000B;
    localparam logic [31:0] CONTROL_WRITE_MASK = 32'h00FF_0008;
    localparam logic [31:0] CONTROL_RESERVED_1 = 32'h0000_0003;
    // Reset values and kilobyte shift
    localparam logic [31:0] KEY_RESET          = 32'h0000_0000;
    localparam logic [31:0] RAM_BASE_ADDR      = 32'hA000_0000;
    localparam int          KB_SHIFT           = 10;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Decoded oscillator sources
    typedef enum logic [2:0]
    {
        OSC_FAST_RC_DIV,
        OSC_PLL,
        OSC_PRIMARY,
        OSC_RESERVED,
        OSC_SECONDARY,
        OSC_LOW_POWER_RC
    } osc_source_type;
endpackage

// ===== hdl/osc_select_decode.sv
// Purpose: Decodes the three-bit oscillator select field
// Assumes: Field is stable after reset capture
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module osc_select_decode
    import sys_config_pkg::*;
(
    input  wire logic [2:0]     osc_source_select,
    output var  osc_source_type osc_source
);
    // Map each code to a source
    always_comb
    begin
        unique case (osc_source_select)
            3'h0:    osc_source = OSC_FAST_RC_DIV;
            3'h1:    osc_source = OSC_PLL;
            3'h2:    osc_source = OSC_PRIMARY;
            3'h3:    osc_source = OSC_RESERVED;
            3'h4:    osc_source = OSC_SECONDARY;
            3'h5:    osc_source = OSC_LOW_POWER_RC;
            default: osc_source = OSC_FAST_RC_DIV;
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/ram_exec_address.sv
// Purpose: Computes the RAM program space start address
// Assumes: Field value counts kilobytes
// Notes:   Zero gives the RAM base itself
`timescale 1ns/100ps
`default_nettype none
module ram_exec_address
    import sys_config_pkg::*;
(
    input  wire logic [7:0]  ram_exec_start,
    output logic      [31:0] exec_start_addr
);
    // Base plus N kilobytes
    always_comb
    begin
        exec_start_addr = RAM_BASE_ADDR | {14'h0000, ram_exec_start, 10'h000};
    end
endmodule
`default_nettype wire

// ===== hdl/system_config_registers.sv
// Purpose: System configuration register bank on AXI4-Lite
// Assumes: Configuration words are stable while reset is asserted
// Notes:   Writes answer two edges after both halves, reads one edge after
`timescale 1ns/100ps
`default_nettype none
module system_config_registers
    import sys_config_pkg::*;
#(
    parameter logic [3:0]  REVISION    = 4'h1,        // Arbitrary value
    parameter logic [27:0] DEVICE_CODE = 28'h0000123  // Arbitrary value
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address channel
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address channel
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // Read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Configuration words from storage
    input  wire logic [31:0] oscillator_select_config,
    input  wire logic [31:0] code_protect_config,
    input  wire logic [31:0] debug_config_word,
    // Decoded outputs
    output logic [2:0]       osc_source,
    output logic             code_protect_enable,
    output logic [31:0]      exec_start_addr,
    output logic             test_port_enable,
    output logic [31:0]      unlock_key,
    output logic             unlock_key_strobe
);
    // Transfer timing at the pins:
    //   write: address and data are taken in either order; once both are
    //          held the register updates and the response rises on the
    //          next edge, two edges after the later half was taken
    //   read:  the word is chosen at the edge that takes the address and
    //          stands on the data channel from the next edge on
    // One write and one read at most are in flight; a channel's ready stays
    // low from its take until its response is accepted, so a second request
    // can never overwrite a held half.
    // Oscillator source, protect enable and start address trail the held words by one register stage.

    // Whole state of the block, kept in one record so that a single
    // register stage holds everything the block remembers
    typedef struct packed
    {
        logic        awready;      // Write address ready flag
        logic        wready;       // Write data ready flag
        logic        aw_held;      // Address captured
        logic [15:0] aw_addr;      // Captured write address
        logic        w_held;       // Data captured
        logic [31:0] w_data;       // Captured write data
        logic [3:0]  w_strb;       // Captured strobes
        logic        bvalid;       // Write response pending
        logic [1:0]  bresp;        // Write response code
        logic        arready;      // Read address ready
        logic        rvalid;       // Read data pending
        logic [31:0] rdata;        // Read data
        logic [1:0]  rresp;        // Read response code
        logic [31:0] osc_cfg;      // Held oscillator word
        logic [31:0] cp_cfg;       // Held code-protect word
        logic [7:0]  ram_exec;     // RAM program start field
        logic        test_port;    // Test port enable
        logic [31:0] key;          // Last key written
        logic        key_strobe;   // Key written pulse
        logic [2:0]  osc_src;      // Registered decoded source
        logic        cp_en;        // Registered protect enable
        logic [31:0] exec_addr;    // Registered start address
        logic        running;      // Channels opened after reset
    } state_type;

    state_type      state_reg;     // Current state
    state_type      state_next;    // Next state
    osc_source_type osc_decoded;   // Decoder output
    logic [31:0]    exec_decoded;  // Address unit output

    // Merge byte lanes into an old word
    // Lanes whose strobe is low keep the old byte
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  strb);
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // Word-aligned register hit test
    // The two low address bits are ignored: any byte of a word hits it
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offset);
        return addr[15:2] == offset[15:2];
    endfunction

    // The decoder and the address unit read held fields only; their
    // results are registered again before they reach the pins
    // Oscillator decoder
    osc_select_decode u_osc_decode
    (
        .osc_source_select (state_reg.osc_cfg[2:0]),
        .osc_source        (osc_decoded)
    );

    // RAM program start address
    ram_exec_address u_exec_addr
    (
        .ram_exec_start  (state_reg.ram_exec),
        .exec_start_addr (exec_decoded)
    );

    // Next-state logic. The block that closes a response comes after the
    // block that raises it, and a new write waits for the old response, so
    // raising and closing never meet in one cycle. Writes to read-only
    // registers answer OKAY and change nothing; addresses outside the map
    // answer SLVERR.
    always_comb
    begin
        logic [31:0] control_word;
        logic [31:0] merged;
        control_word = 32'h0000_0000;
        merged       = 32'h0000_0000;
        state_next   = state_reg;
        // Key strobe is a single-cycle pulse
        state_next.key_strobe = 1'b0;
        // Derived outputs follow the held words one edge later
        state_next.osc_src    = osc_decoded;
        state_next.cp_en      = ~state_reg.cp_cfg[CODE_PROTECT_BIT];
        state_next.exec_addr  = exec_decoded;
        // Readable image of config_control
        control_word[RAM_EXEC_MSB:RAM_EXEC_LSB] = state_reg.ram_exec;
        control_word[TEST_PORT_BIT]             = state_reg.test_port;
        control_word = (control_word | CONTROL_RESERVED_1) & CONTROL_READ_MASK;

        if (!aresetn)
        begin
            // Capture configuration words during reset
            // Readies stay low here and open one edge after release, so
            // no request can land in a capture cycle
            state_next = '0;
            state_next.osc_cfg   = oscillator_select_config;
            state_next.cp_cfg    = code_protect_config;
            state_next.test_port = debug_config_word[DEBUG_TEST_BIT];
            state_next.key       = KEY_RESET;
        end
        else
        begin
            // Open all channels on the first edge after reset release
            if (!state_reg.running)
            begin
                state_next.running = 1'b1;
                state_next.awready = 1'b1;
                state_next.wready  = 1'b1;
                state_next.arready = 1'b1;
            end

            // Accept write address
            if (s_axi_awvalid && state_reg.awready)
            begin
                state_next.aw_held = 1'b1;
                state_next.aw_addr = s_axi_awaddr;
                state_next.awready = 1'b0;
            end

            // Accept write data
            if (s_axi_wvalid && state_reg.wready)
            begin
                state_next.w_held = 1'b1;
                state_next.w_data = s_axi_wdata;
                state_next.w_strb = s_axi_wstrb;
                state_next.wready = 1'b0;
            end

            // Perform write when both halves are present
            if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid)
            begin
                state_next.aw_held = 1'b0;
                state_next.w_held  = 1'b0;
                state_next.bvalid  = 1'b1;
                state_next.bresp   = RESP_OKAY;
                if (addr_hit(state_reg.aw_addr, OFFSET_CONFIG_CONTROL))
                begin
                    // Only the program start field and test port bit store
                    merged = merge_bytes(control_word, state_reg.w_data, state_reg.w_strb);
                    state_next.ram_exec  = merged[RAM_EXEC_MSB:RAM_EXEC_LSB];
                    state_next.test_port = merged[TEST_PORT_BIT];
                end
                else if (addr_hit(state_reg.aw_addr, OFFSET_UNLOCK_KEY))
                begin
                    // Lanes without a strobe are stored as zero
                    state_next.key        = merge_bytes(32'h0000_0000, state_reg.w_data,
                                                        state_reg.w_strb);
                    state_next.key_strobe = 1'b1;
                end
                else if (addr_hit(state_reg.aw_addr, OFFSET_DEVICE_IDENTITY) ||
                         addr_hit(state_reg.aw_addr, OFFSET_OSC_SELECT_CONFIG) ||
                         addr_hit(state_reg.aw_addr, OFFSET_CODE_PROTECT_CFG))
                begin
                    // Read-only registers ignore writes
                    state_next.bresp = RESP_OKAY;
                end
                else
                begin
                    // Outside the map: refuse and store nothing
                    state_next.bresp = RESP_SLVERR;
                end
            end

            // Write response handshake
            if (state_reg.bvalid && s_axi_bready)
            begin
                state_next.bvalid  = 1'b0;
                state_next.awready = 1'b1;
                state_next.wready  = 1'b1;
            end

            // Read address accepted; the word is chosen now and stands
            // from the next edge until it is taken
            if (s_axi_arvalid && state_reg.arready)
            begin
                state_next.arready = 1'b0;
                state_next.rvalid  = 1'b1;
                state_next.rresp   = RESP_OKAY;
                if (addr_hit(s_axi_araddr, OFFSET_CONFIG_CONTROL))
                begin
                    state_next.rdata = control_word;
                end
                else if (addr_hit(s_axi_araddr, OFFSET_DEVICE_IDENTITY))
                begin
                    state_next.rdata = {REVISION, DEVICE_CODE};
                end
                else if (addr_hit(s_axi_araddr, OFFSET_UNLOCK_KEY))
                begin
                    state_next.rdata = 32'h0000_0000;
                end
                else if (addr_hit(s_axi_araddr, OFFSET_OSC_SELECT_CONFIG))
                begin
                    state_next.rdata = state_reg.osc_cfg;
                end
                else if (addr_hit(s_axi_araddr, OFFSET_CODE_PROTECT_CFG))
                begin
                    state_next.rdata = state_reg.cp_cfg;
                end
                else
                begin
                    // Outside the map: zero data with an error
                    state_next.rdata = 32'h0000_0000;
                    state_next.rresp = RESP_SLVERR;
                end
            end

            // Read data handshake
            if (state_reg.rvalid && s_axi_rready)
            begin
                state_next.rvalid  = 1'b0;
                state_next.arready = 1'b1;
            end
        end
    end

    // State register; reset is synchronous, so the capture branch above
    // is what runs on every edge that sees reset low
    always_ff @(posedge aclk)
    begin
        state_reg <= state_next;
    end

    // Every output is a field of the state register with no gate after
    // it, so the pins carry clean levels
    assign s_axi_awready       = state_reg.awready;
    assign s_axi_wready        = state_reg.wready;
    assign s_axi_arready       = state_reg.arready;
    assign s_axi_bvalid        = state_reg.bvalid;
    assign s_axi_bresp         = state_reg.bresp;
    assign s_axi_rvalid        = state_reg.rvalid;
    assign s_axi_rdata         = state_reg.rdata;
    assign s_axi_rresp         = state_reg.rresp;
    assign osc_source          = state_reg.osc_src;
    assign code_protect_enable = state_reg.cp_en;
    assign exec_start_addr     = state_reg.exec_addr;
    assign test_port_enable    = state_reg.test_port;
    assign unlock_key          = state_reg.key;
    assign unlock_key_strobe   = state_reg.key_strobe;
endmodule
`default_nettype wire

// ===== tb/sys_config_properties.sv
// Purpose: Port-level timing and value checks for the configuration bank
// Assumes: Configuration words change only while reset is low
// Notes:   Bound to the design from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module sys_config_properties
    import sys_config_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] oscillator_select_config,
    input wire logic [31:0] code_protect_config,
    input wire logic [2:0]  osc_source,
    input wire logic        code_protect_enable,
    input wire logic [31:0] exec_start_addr,
    input wire logic        test_port_enable,
    input wire logic        unlock_key_strobe
);
    logic [15:0] rd_addr_reg; // Address of the read under way
    // Remember the read address so the answer can be judged
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_reg <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Settled at least two edges after reset
    sequence settled;
        $past(aresetn, 2) && $past(aresetn);
    endsequence
    a_write_answer_time: assert property
        (wr_taken |-> ##1 !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer not two cycles after acceptance");
    a_read_answer_time: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer not one cycle after acceptance");
    a_write_resp_hold: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_read_data_hold: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_osc_decode_map: assert property
        (settled |-> osc_source == ((oscillator_select_config[2:1] == 2'h3) ? 3'h0
                                    : oscillator_select_config[2:0]))
        else $error("oscillator source decoded wrongly");
    a_protect_level: assert property
        (settled |-> code_protect_enable == !code_protect_config[CODE_PROTECT_BIT])
        else $error("code protection level wrong");
    a_exec_kb_align: assert property
        (settled |-> exec_start_addr[31:18] == RAM_BASE_ADDR[31:18]
                     && exec_start_addr[9:0] == 10'h0)
        else $error("program space start off its boundary");
    a_key_strobe_pulse: assert property (unlock_key_strobe |=> !unlock_key_strobe)
        else $error("key strobe longer than one cycle");
    a_key_reads_zero: assert property
        (s_axi_rvalid && rd_addr_reg == OFFSET_UNLOCK_KEY |-> s_axi_rdata == 32'h0)
        else $error("key register read not zero");
    a_control_read_mask: assert property
        (s_axi_rvalid && rd_addr_reg == OFFSET_CONFIG_CONTROL
         |-> (s_axi_rdata & ~CONTROL_READ_MASK) == 32'h0
             && s_axi_rdata[TEST_PORT_BIT] == test_port_enable)
        else $error("control read shows unimplemented bits or wrong port bit");
endmodule
`default_nettype wire

// ===== tb/config_storage_model.sv
// Purpose: Non-volatile configuration storage as seen by the bank
// Assumes: Words are only changed by the bench while reset is low
// Notes:   Every reserved position is programmed as one
`timescale 1ns/100ps
`default_nettype none
module config_storage_model
(
    input  wire logic [2:0]  osc_code,
    input  wire logic        protect_n,
    input  wire logic        debug_test,
    output logic      [31:0] osc_word,
    output logic      [31:0] protect_word,
    output logic      [31:0] debug_word
);
    // Oscillator word: select code in the low bits
    assign osc_word     = {29'h1FFF_FFFF, osc_code};
    // Code-protect word: reserved bits held at one
    assign protect_word = {protect_n, 31'h7FFF_FFFF};
    // Debug word: test port default in bit 2
    assign debug_word   = {29'h1FFF_FFFF, debug_test, 2'h3};
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Bench acts as AXI4-Lite master, one transfer at a time
// Notes:   Configuration words change only inside reset
`timescale 1ns/100ps
`default_nettype none
module tb
    import sys_config_pkg::*;
;
    localparam logic [3:0]  REV  = 4'h9;        // Arbitrary value
    localparam logic [27:0] CODE = 28'h0ABCDEF; // Arbitrary value
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, oscillator_select_config, code_protect_config, debug_config_word;
    logic [31:0] exec_start_addr, unlock_key;
    logic [2:0]  osc_source, osc_code = 3'h0;
    logic        code_protect_enable, test_port_enable, unlock_key_strobe;
    logic        protect_n = 1'h1, debug_test = 1'h1;
    int          bad_count = 0, check_count = 0, strobe_count = 0;
    // Free-running 100 MHz clock
    always #5 aclk = ~aclk;
    config_storage_model storage (.osc_code, .protect_n, .debug_test,
        .osc_word(oscillator_select_config), .protect_word(code_protect_config),
        .debug_word(debug_config_word));
    system_config_registers #(.REVISION(REV), .DEVICE_CODE(CODE)) dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscillator_select_config,
        .code_protect_config, .debug_config_word, .osc_source, .code_protect_enable,
        .exec_start_addr, .test_port_enable, .unlock_key, .unlock_key_strobe);
    // Count key strobe pulses
    always @(posedge aclk) if (unlock_key_strobe === 1'h1) strobe_count++;
    task automatic report_and_stop;
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    // Write: address and data offered together, each released once taken
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        check_resp("bresp", r, s_axi_bresp);
    endtask
    // Read: data compared only when an OKAY answer is expected
    task automatic axi_read(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        check_resp("rresp", r, s_axi_rresp);
        if (r === RESP_OKAY) check32("rdata", exp, s_axi_rdata);
    endtask
    // Reset with fresh words, then wait until outputs settle
    task automatic do_reset(input logic [2:0] c, input logic p, input logic d);
        @(posedge aclk);
        aresetn <= 1'h0;
        osc_code <= c;
        protect_n <= p;
        debug_test <= d;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(negedge aclk);
    endtask
    // Control reset value follows the debug word; code-protect word read-only
    task automatic t_reset_control;
        for (int d = 0; d < 2; d++)
        begin
            do_reset(3'h2, 1'h0, d[0]);
            check32("test_port_enable", {31'h0, d[0]}, {31'h0, test_port_enable});
            check32("exec_start_addr", RAM_BASE_ADDR, exec_start_addr);
            axi_read(OFFSET_CONFIG_CONTROL, {28'h0, d[0], 3'h3}, RESP_OKAY);
            axi_write(OFFSET_CODE_PROTECT_CFG, 32'h0, 4'hF, RESP_OKAY);
            axi_read(OFFSET_CODE_PROTECT_CFG, 32'h7FFF_FFFF, RESP_OKAY);
        end
    endtask
    // Control write: start field, port bit, unimplemented bits dropped
    task automatic t_exec(input logic [31:0] wd);
        logic [31:0] addr;
        addr = RAM_BASE_ADDR + (32'(wd[23:16]) << KB_SHIFT);
        axi_write(OFFSET_CONFIG_CONTROL, wd, 4'hF, RESP_OKAY);
        @(negedge aclk);
        check32("exec_start_addr", addr, exec_start_addr);
        check32("test_port_enable", {31'h0, wd[3]}, {31'h0, test_port_enable});
        axi_read(OFFSET_CONFIG_CONTROL, {8'h0, wd[23:16], 12'h0, wd[3], 3'h3},
                 RESP_OKAY);
    endtask
    // Identity is fixed and ignores writes
    task automatic t_identity;
        axi_read(OFFSET_DEVICE_IDENTITY, {REV, CODE}, RESP_OKAY);
        axi_write(OFFSET_DEVICE_IDENTITY, 32'h0, 4'hF, RESP_OKAY);
        axi_read(OFFSET_DEVICE_IDENTITY, {REV, CODE}, RESP_OKAY);
    endtask
    // Key: full and partial writes, one strobe each, reads as zero
    task automatic t_key;
        int s0;
        s0 = strobe_count;
        axi_write(OFFSET_UNLOCK_KEY, 32'h1234_5678, 4'hF, RESP_OKAY);
        repeat (2) @(negedge aclk);
        check32("unlock_key", 32'h1234_5678, unlock_key);
        check32("strobe count", 32'(s0 + 1), 32'(strobe_count));
        axi_read(OFFSET_UNLOCK_KEY, 32'h0, RESP_OKAY);
        axi_write(OFFSET_UNLOCK_KEY, 32'hAAAA_BBBB, 4'h3, RESP_OKAY);
        repeat (2) @(negedge aclk);
        check32("unlock_key", 32'h0000_BBBB, unlock_key);
        check32("strobe count", 32'(s0 + 2), 32'(strobe_count));
    endtask
    // Unmapped addresses answer with an error
    task automatic t_unmapped;
        axi_read(16'h3B10, 32'h0, RESP_SLVERR);
        axi_write(16'h3B60, 32'h0, 4'hF, RESP_SLVERR);
    endtask
    // Every select code, alternating protection
    task automatic t_osc_codes;
        logic [31:0] exp;
        for (int i = 0; i < 8; i++)
        begin
            do_reset(i[2:0], i[0], 1'h1);
            exp = (i >= 6) ? 32'h0 : 32'(i);
            check32("osc_source", exp, {29'h0, osc_source});
            check32("code_protect", {31'h0, ~i[0]}, {31'h0, code_protect_enable});
            axi_read(OFFSET_OSC_SELECT_CONFIG, {29'h1FFF_FFFF, i[2:0]}, RESP_OKAY);
        end
    endtask
    // Main sequence
    initial
    begin
        t_reset_control();
        t_exec(32'h0000_0003);
        t_exec(32'h0001_000B);
        t_exec(32'h0002_0003);
        t_exec(32'hF4FF_FFF7);
        t_identity();
        t_key();
        t_unmapped();
        t_osc_codes();
        report_and_stop();
    end
    // Watchdog against a hung handshake
    initial
    begin
        #100000;
        bad_count++;
        report_and_stop();
    end
endmodule
bind system_config_registers sys_config_properties chk (.*);
`default_nettype wire
